// ===== shared/pll_clock_pkg.sv
// Notes on behaviour
// - Base clock is crystal or loop clock halved
// - Bus clock runs at half the base clock
// - Base select set ignored while loop unpowered
// - Prescaler field resets clear, locked while powered
// - Prescaler exponent equals code, multiplier 1..8
// - Range field resets clear, locked while powered
// - Range exponent equals code, multiplier 1..8
// - Upper four high multiplier bits read zero
// - Low multiplier byte locked while loop powered
// - Multiplier zero gives a divider of one, but reads back zero
`default_nettype none
package pll_clock_pkg;

    // Bus geometry
    localparam int unsigned addr_width = 12;
    localparam int unsigned data_width = 32;
    localparam int unsigned reg_width = 8;

    // Register byte addresses
    localparam logic [11:0] control_addr = 12'h000;
    localparam logic [11:0] mult_high_addr = 12'h004;
    localparam logic [11:0] mult_low_addr = 12'h008;
    localparam logic [11:0] status_addr = 12'h00c;

    // Control register field positions
    localparam int unsigned range_lsb = 0;
    localparam int unsigned range_msb = 1;
    localparam int unsigned pre_lsb = 2;
    localparam int unsigned pre_msb = 3;
    localparam int unsigned select_bit = 4;
    localparam int unsigned power_bit = 5;

    // Multiplier field widths
    localparam int unsigned mult_high_width = 4;
    localparam int unsigned mult_width = 12;
    localparam int unsigned code_width = 2;
    localparam int unsigned factor_width = 4;

    // Reset values
    localparam logic [1:0] pre_reset = 2'h0;
    localparam logic [1:0] range_reset = 2'h0;
    localparam logic [3:0] mult_high_reset = 4'h0;
    localparam logic [7:0] mult_low_reset = 8'h40;

    // Divider constants
    localparam logic [11:0] mult_zero = 12'h000;
    localparam logic [11:0] mult_one = 12'h001;
    localparam logic [3:0] factor_one = 4'h1;
    localparam int unsigned sync_stages = 2;

    // Clock source choices
    typedef enum logic [1:0] {
        src_crystal_type_val = 2'b01,
        src_vco_type_val = 2'b10
    } source_type;

endpackage : pll_clock_pkg
`default_nettype wire

// ===== rtl/clock_halver.sv
`timescale 1ns/1ps
`default_nettype none
module clock_halver #(
    parameter int unsigned SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Clock to be halved
    input wire logic src,
    // Halved clock, from a flip-flop
    output logic half_ff
);

    // Either a full synchroniser or none at all, refused at elaboration
    generate
        if (SYNC_STAGES != 0 && SYNC_STAGES != 2) begin : g_bad_stages
            $error("clock_halver: SYNC_STAGES must be 0 or 2");
        end
    endgenerate

    // Source as seen in the pclk domain
    logic level;
    // Previous sampled level for edge detection
    logic last_ff;
    // Rising edge of the sampled source
    wire rise = level & ~last_ff;

    generate
        if (SYNC_STAGES == 2) begin : g_sync
            // First stage is read only by the second
            logic meta_ff;
            logic safe_ff;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_ff <= 1'b0;
                    safe_ff <= 1'b0;
                end else begin
                    meta_ff <= src;
                    safe_ff <= meta_ff;
                end
            end
            assign level = safe_ff;
        end else begin : g_direct
            // Already in the pclk domain
            assign level = src;
        end
    endgenerate

    // Toggle on each rising edge, halving the rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ff <= 1'b0;
            half_ff <= 1'b0;
        end else begin
            last_ff <= level;
            half_ff <= rise ? ~half_ff : half_ff;
        end
    end

endmodule : clock_halver
`default_nettype wire

// ===== rtl/pll_clock_program_logic.sv
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pll_clock_program_logic (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pll_clock_pkg::addr_width-1:0] paddr,
    input wire logic [pll_clock_pkg::data_width-1:0] pwdata,
    input wire logic [3:0] pstrb,
    // APB answer
    output logic pready,
    output logic [pll_clock_pkg::data_width-1:0] prdata,
    output logic pslverr,
    // Clock sources from outside
    input wire logic crystal_clock,
    input wire logic vco_clock,
    // Derived clocks
    output logic base_clock_out,
    output logic bus_clock_out,
    // Settings toward the analogue loop
    output logic pll_power_on,
    output logic base_clock_select,
    output logic [pll_clock_pkg::code_width-1:0] prescaler_select,
    output logic [pll_clock_pkg::factor_width-1:0] prescaler_multiplier,
    output logic [pll_clock_pkg::code_width-1:0] vco_range_select,
    output logic [pll_clock_pkg::factor_width-1:0] vco_range_multiplier,
    output logic [pll_clock_pkg::mult_width-1:0] feedback_divider
);

    import pll_clock_pkg::*;

    // Package geometry must match the 8-bit registers and the word bus
    generate
        if (mult_width != mult_high_width + reg_width) begin : g_bad_mult
            $error("pll_clock_program_logic: multiplier widths disagree");
        end
        if (power_bit >= reg_width || data_width < mult_width + 2) begin : g_bad_fields
            $error("pll_clock_program_logic: control or status fields do not fit");
        end
    endgenerate

    // Register state

    // Loop power enable
    logic power_ff;
    // Base source is the loop clock when set
    logic select_ff;
    // Prescaler code
    logic [code_width-1:0] pre_ff;
    // Oscillator range code
    logic [code_width-1:0] range_ff;
    // Upper nibble of the feedback multiplier
    logic [mult_high_width-1:0] mult_high_ff;
    // Low byte of the feedback multiplier
    logic [reg_width-1:0] feedback_multiplier_low_ff;

    // Next loop power enable
    logic nxt_power;
    // Next base source select
    logic nxt_select;
    // Next prescaler code
    logic [code_width-1:0] nxt_pre;
    // Next oscillator range code
    logic [code_width-1:0] nxt_range;
    // Next upper multiplier nibble
    logic [mult_high_width-1:0] nxt_mult_high;
    // Next low multiplier byte
    logic [reg_width-1:0] nxt_mult_low;

    // Read data held for the access phase
    logic [data_width-1:0] rdata_ff;
    // Read data chosen in the setup phase
    logic [data_width-1:0] nxt_rdata;
    // Unmapped address seen in the setup phase
    logic slverr_ff;
    // Next unmapped flag
    logic nxt_slverr;

    // Feedback divider with zero shown as one
    logic [mult_width-1:0] divider_ff;
    // Divider value for the next edge
    logic [mult_width-1:0] nxt_divider;
    // Prescaler factor, one shifted by the code
    logic [factor_width-1:0] pre_mult_ff;
    // Range factor, one shifted by the code
    logic [factor_width-1:0] range_mult_ff;

    // Bus decode

    // Setup phase, when read data is prepared
    wire setup_phase = psel & ~penable;
    // Access phase completes in one cycle
    wire access_phase = psel & penable;
    // Write taking effect at this edge
    wire write_now = access_phase & pwrite & pstrb[0];

    // Control register addressed
    wire hit_control = (paddr == control_addr);
    // Upper multiplier register addressed
    wire hit_high = (paddr == mult_high_addr);
    // Low multiplier register addressed
    wire hit_low = (paddr == mult_low_addr);
    // Status register addressed
    wire hit_status = (paddr == status_addr);
    // Any mapped register addressed
    wire hit_any = hit_control | hit_high | hit_low | hit_status;

    // Control register write strobe
    wire wr_control = write_now & hit_control;
    // Upper multiplier write strobe
    wire wr_high = write_now & hit_high;
    // Low multiplier write strobe
    wire wr_low = write_now & hit_low;

    // Write data fields
    wire [reg_width-1:0] wbyte = pwdata[reg_width-1:0];
    wire w_power = wbyte[power_bit];
    wire w_select = wbyte[select_bit];
    wire [code_width-1:0] w_pre = wbyte[pre_msb:pre_lsb];
    wire [code_width-1:0] w_range = wbyte[range_msb:range_lsb];
    // Multiplier nibble, upper write bits dropped
    wire [mult_high_width-1:0] w_high = wbyte[mult_high_width-1:0];

    // Multiplier settings may change only with the loop off
    wire settings_open = ~power_ff;

    // Next-value logic for the control register

    // Power and select interlock, both judged on current state
    always_comb begin
        nxt_power = power_ff;
        nxt_select = select_ff;
        if (wr_control) begin
            // Power may rise freely; falling needs select clear
            if (w_power || !select_ff) begin
                nxt_power = w_power;
            end
            // Select may fall freely; rising needs power on
            if (!w_select || power_ff) begin
                nxt_select = w_select;
            end
        end
    end

    // Prescaler and range codes, locked while powered
    always_comb begin
        nxt_pre = pre_ff;
        nxt_range = range_ff;
        if (wr_control && settings_open) begin
            nxt_pre = w_pre;
            nxt_range = w_range;
        end
    end

    // Next-value logic for the multiplier registers

    // Both multiplier bytes share the same lock
    always_comb begin
        nxt_mult_high = mult_high_ff;
        nxt_mult_low = feedback_multiplier_low_ff;
        if (wr_high && settings_open) begin
            // Only the lower nibble exists
            nxt_mult_high = w_high;
        end
        if (wr_low && settings_open) begin
            nxt_mult_low = wbyte;
        end
    end

    // Combined multiplier, zero treated as one
    wire [mult_width-1:0] mult_raw = {nxt_mult_high, nxt_mult_low};
    assign nxt_divider = (mult_raw == mult_zero) ? mult_one : mult_raw;

    // Power-of-two factors from the codes
    wire [factor_width-1:0] nxt_pre_mult = factor_one << nxt_pre;
    wire [factor_width-1:0] nxt_range_mult = factor_one << nxt_range;

    // Register storage

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_ff <= 1'b0;
            select_ff <= 1'b0;
            pre_ff <= pre_reset;
            range_ff <= range_reset;
        end else begin
            power_ff <= nxt_power;
            select_ff <= nxt_select;
            pre_ff <= nxt_pre;
            range_ff <= nxt_range;
        end
    end

    // Multiplier registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mult_high_ff <= mult_high_reset;
            feedback_multiplier_low_ff <= mult_low_reset;
        end else begin
            mult_high_ff <= nxt_mult_high;
            feedback_multiplier_low_ff <= nxt_mult_low;
        end
    end

    // Derived settings kept in flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            divider_ff <= {mult_high_reset, mult_low_reset};
            pre_mult_ff <= factor_one;
            range_mult_ff <= factor_one;
        end else begin
            divider_ff <= nxt_divider;
            pre_mult_ff <= nxt_pre_mult;
            range_mult_ff <= nxt_range_mult;
        end
    end

    // Read path

    // Control image: power, select, prescaler, range; unused bits zero
    wire [data_width-1:0] img_control = {{(data_width-power_bit-1){1'b0}},
        power_ff, select_ff, pre_ff, range_ff};
    // High multiplier image, upper nibble zero
    wire [data_width-1:0] img_high = {{(data_width-mult_high_width){1'b0}},
        mult_high_ff};
    // Low multiplier image
    wire [data_width-1:0] img_low = {{(data_width-reg_width){1'b0}},
        feedback_multiplier_low_ff};
    // Status image: select, power, effective divider
    wire [data_width-1:0] img_status = {{(data_width-mult_width-2){1'b0}},
        select_ff, power_ff, divider_ff};

    // Select the image for the addressed register
    always_comb begin
        nxt_rdata = rdata_ff;
        nxt_slverr = slverr_ff;
        if (setup_phase) begin
            nxt_slverr = ~hit_any;
            unique case (1'b1)
                hit_control: begin
                    nxt_rdata = img_control;
                end
                hit_high: begin
                    nxt_rdata = img_high;
                end
                hit_low: begin
                    nxt_rdata = img_low;
                end
                hit_status: begin
                    nxt_rdata = img_status;
                end
                default: begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    // Answer held from setup through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= '0;
            slverr_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            slverr_ff <= nxt_slverr;
        end
    end

    // Zero-wait slave: every access completes in its first cycle
    assign pready = 1'b1;
    // Read data straight from its flip-flop
    assign prdata = rdata_ff;
    // Error shown only while the access phase stands
    assign pslverr = access_phase & slverr_ff;

    // Clock path

    // Crystal clock halved after synchronising
    logic crystal_half;
    clock_halver #(
        .SYNC_STAGES(sync_stages)
    ) u_crystal_half (
        .pclk(pclk),
        .presetn(presetn),
        .src(crystal_clock),
        .half_ff(crystal_half)
    );

    // Loop clock halved after synchronising
    logic vco_half;
    clock_halver #(
        .SYNC_STAGES(sync_stages)
    ) u_vco_half (
        .pclk(pclk),
        .presetn(presetn),
        .src(vco_clock),
        .half_ff(vco_half)
    );

    // Chosen source, registered to avoid a glitching mux
    logic base_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_ff <= 1'b0;
        end else begin
            base_ff <= select_ff ? vco_half : crystal_half;
        end
    end

    // Bus clock halves the base clock again
    logic bus_half;
    clock_halver #(
        .SYNC_STAGES(0)
    ) u_bus_half (
        .pclk(pclk),
        .presetn(presetn),
        .src(base_ff),
        .half_ff(bus_half)
    );

    // Outputs

    // Clocks
    assign base_clock_out = base_ff;
    assign bus_clock_out = bus_half;

    // Settings
    assign pll_power_on = power_ff;
    assign base_clock_select = select_ff;
    assign prescaler_select = pre_ff;
    assign prescaler_multiplier = pre_mult_ff;
    assign vco_range_select = range_ff;
    assign vco_range_multiplier = range_mult_ff;
    assign feedback_divider = divider_ff;

endmodule : pll_clock_program_logic
`default_nettype wire

// ===== bench/pll_clock_program_logic_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module pll_clock_program_logic_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pll_clock_pkg::addr_width-1:0] paddr,
    input wire logic [pll_clock_pkg::data_width-1:0] pwdata,
    input wire logic [3:0] pstrb,
    // Bus answer
    input wire logic pready,
    input wire logic [pll_clock_pkg::data_width-1:0] prdata,
    input wire logic pslverr,
    // Clocks
    input wire logic crystal_clock,
    input wire logic vco_clock,
    input wire logic base_clock_out,
    input wire logic bus_clock_out,
    // Settings
    input wire logic pll_power_on,
    input wire logic base_clock_select,
    input wire logic [pll_clock_pkg::code_width-1:0] prescaler_select,
    input wire logic [pll_clock_pkg::factor_width-1:0] prescaler_multiplier,
    input wire logic [pll_clock_pkg::code_width-1:0] vco_range_select,
    input wire logic [pll_clock_pkg::factor_width-1:0] vco_range_multiplier,
    input wire logic [pll_clock_pkg::mult_width-1:0] feedback_divider
);
    import pll_clock_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Accepted write to the control register
    sequence s_ctrl_wr;
        psel && penable && pwrite && pstrb[0] && paddr == control_addr;
    endsequence
    // Same write while the loop is powered
    sequence s_ctrl_wr_on;
        s_ctrl_wr ##0 pll_power_on;
    endsequence
    a_select_power: assert property ($rose(base_clock_select) |-> $past(pll_power_on))
        else $error("select set without power");
    a_select_write: assert property (s_ctrl_wr_on |=> base_clock_select == $past(pwdata[4]))
        else $error("select write lost");
    a_power_kept: assert property ($fell(pll_power_on) |-> !$past(base_clock_select))
        else $error("power dropped under select");
    a_pre_write: assert property (s_ctrl_wr ##0 !pll_power_on
        |=> prescaler_select == $past(pwdata[3:2]))
        else $error("prescaler write lost");
    a_pre_locked: assert property (pll_power_on |=> $stable(prescaler_select))
        else $error("prescaler changed while powered");
    a_range_locked: assert property (pll_power_on |=> $stable(vco_range_select))
        else $error("range changed while powered");
    a_mult_locked: assert property (pll_power_on |=> $stable(feedback_divider))
        else $error("divider changed while powered");
    a_pre_factor: assert property (prescaler_multiplier == 4'h1 << prescaler_select)
        else $error("prescaler factor wrong");
    a_range_factor: assert property (vco_range_multiplier == 4'h1 << vco_range_select)
        else $error("range factor wrong");
    a_divider_floor: assert property (feedback_divider != 12'h000)
        else $error("divider shows zero");
    a_bus_half: assert property ($changed(bus_clock_out) |=> $stable(bus_clock_out))
        else $error("bus clock too fast");
    // Base clock seen low, then high
    sequence s_base_rise;
        !base_clock_out ##1 base_clock_out;
    endsequence
    a_bus_follow: assert property (s_base_rise |=> $changed(bus_clock_out))
        else $error("bus clock missed a base rise");
    a_bus_cause: assert property ($changed(bus_clock_out) |->
        $past(base_clock_out) && !$past(base_clock_out, 2))
        else $error("bus clock moved without a base rise");
endmodule : pll_clock_program_logic_monitor
bind pll_clock_program_logic pll_clock_program_logic_monitor mon (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .crystal_clock(crystal_clock),
    .vco_clock(vco_clock),
    .base_clock_out(base_clock_out),
    .bus_clock_out(bus_clock_out),
    .pll_power_on(pll_power_on),
    .base_clock_select(base_clock_select),
    .prescaler_select(prescaler_select),
    .prescaler_multiplier(prescaler_multiplier),
    .vco_range_select(vco_range_select),
    .vco_range_multiplier(vco_range_multiplier),
    .feedback_divider(feedback_divider)
);
`default_nettype wire

// ===== bench/pll_clock_program_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pll_clock_program_logic_tb;
    import pll_clock_pkg::*;
    // Bus and clock signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic crystal_clock, vco_clock, base_clock_out, bus_clock_out;
    // Settings seen at the ports
    logic pll_power_on, base_clock_select;
    logic [1:0] prescaler_select, vco_range_select;
    logic [3:0] prescaler_multiplier, vco_range_multiplier;
    logic [11:0] feedback_divider;
    // Bookkeeping
    int n_errors, n_tests, nb, nu;
    logic [31:0] rd;
    logic er;

    pll_clock_program_logic dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .crystal_clock(crystal_clock),
        .vco_clock(vco_clock),
        .base_clock_out(base_clock_out),
        .bus_clock_out(bus_clock_out),
        .pll_power_on(pll_power_on),
        .base_clock_select(base_clock_select),
        .prescaler_select(prescaler_select),
        .prescaler_multiplier(prescaler_multiplier),
        .vco_range_select(vco_range_select),
        .vco_range_multiplier(vco_range_multiplier),
        .feedback_divider(feedback_divider)
    );

    // Clocks: bus 8 ns, crystal 80 ns, loop 48 ns
    initial begin
        pclk = 0; crystal_clock = 0; vco_clock = 0; presetn = 0;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
    end
    always #4 pclk = ~pclk;
    always #40 crystal_clock = ~crystal_clock;
    always #24 vco_clock = ~vco_clock;

    // Verdict and end of run
    task conclude;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // Exact compare of a bus or port value
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Compare of an edge count against a window
    task chk_rng(input int got, input int lo, input int hi, input string what);
        n_tests++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("wrong value at %0t: %s count %0d", $time, what, got);
        end
    endtask : chk_rng

    // One bus transfer, setup then access until ready
    task xfer(input logic is_write, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1;
        pwrite <= is_write;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: no ready", $time);
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask : xfer

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    // Read and compare, no error expected
    task rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp, what);
        chk(32'(er), 32'h0, "error flag");
    endtask : rdc

    // Count rising edges of base and bus clocks
    task count_clk(input int cycles);
        logic pb, pu;
        nb = 0; nu = 0; pb = base_clock_out; pu = bus_clock_out;
        repeat (cycles) begin
            @(posedge pclk);
            if (base_clock_out === 1'b1 && pb === 1'b0) nb++;
            if (bus_clock_out === 1'b1 && pu === 1'b0) nu++;
            pb = base_clock_out;
            pu = bus_clock_out;
        end
    endtask : count_clk

    task do_reset;
        presetn <= 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
    endtask : do_reset

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        $display("wrong value at %0t: run timed out", $time);
        conclude();
    end

    initial begin
        do_reset();
        rdc(control_addr, 32'h0, "ctrl reset");
        rdc(mult_high_addr, 32'h0, "high reset");
        rdc(mult_low_addr, 32'h40, "low reset");
        rdc(status_addr, 32'h040, "status reset");
        // Crystal source, base 20 cycles, bus 40
        count_clk(240);
        chk_rng(nb, 11, 13, "base crystal");
        chk_rng(nu, 5, 7, "bus crystal");
        // Every prescaler code, range codes kept below 3
        for (int i = 0; i < 4; i++) begin
            wr(control_addr, 32'(i * 4 + i % 3));
            rdc(control_addr, 32'(i * 4 + i % 3), "codes");
            chk(32'({prescaler_select, vco_range_select}), 32'(i * 4 + i % 3), "code pins");
            chk(32'(prescaler_multiplier), 32'(1 << i), "pre factor");
            chk(32'(vco_range_multiplier), 32'(1 << (i % 3)), "range factor");
        end
        wr(control_addr, 32'h0);
        wr(mult_high_addr, 32'hff);
        rdc(mult_high_addr, 32'h0f, "high nibble");
        wr(mult_high_addr, 32'h0);
        wr(mult_low_addr, 32'h0);
        rdc(mult_low_addr, 32'h0, "low zero");
        chk(32'(feedback_divider), 32'h1, "divider zero");
        rdc(status_addr, 32'h001, "status zero");
        wr(mult_low_addr, 32'h9a);
        rdc(mult_low_addr, 32'h9a, "low write");
        chk(32'(feedback_divider), 32'h09a, "divider write");
        // Select refused while unpowered, even with power in same write
        wr(control_addr, 32'h10);
        rdc(control_addr, 32'h0, "select off");
        wr(control_addr, 32'h30);
        rdc(control_addr, 32'h20, "select same write");
        // Fields locked while powered
        wr(control_addr, 32'h2e);
        rdc(control_addr, 32'h20, "ctrl locked");
        wr(mult_low_addr, 32'h55);
        rdc(mult_low_addr, 32'h9a, "low locked");
        wr(mult_high_addr, 32'h3);
        rdc(mult_high_addr, 32'h0, "high locked");
        // Loop clock selected in a second write
        wr(control_addr, 32'h30);
        rdc(control_addr, 32'h30, "select on");
        chk(32'({pll_power_on, base_clock_select}), 32'h3, "loop pins");
        repeat (16) @(posedge pclk);
        count_clk(240);
        chk_rng(nb, 19, 21, "base loop");
        chk_rng(nu, 9, 11, "bus loop");
        // Power kept while selected
        wr(control_addr, 32'h10);
        rdc(control_addr, 32'h30, "power kept");
        wr(control_addr, 32'h0);
        rdc(control_addr, 32'h20, "select dropped");
        wr(control_addr, 32'h0);
        rdc(control_addr, 32'h0, "power off");
        // Unmapped place
        xfer(1'b0, 12'h010, 32'h0);
        chk(32'(er), 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        // Second reset restores the default
        wr(mult_low_addr, 32'h11);
        rdc(mult_low_addr, 32'h11, "low before reset");
        do_reset();
        rdc(mult_low_addr, 32'h40, "low after reset");
        conclude();
    end
endmodule : pll_clock_program_logic_tb
`default_nettype wire
